// ### core/rdt_top.sv
`timescale 1ns/10ps
`default_nettype none
module rdt_top #(
    parameter int CHANNELS = 2
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CHANNELS-1:0] timerEventInputPin,
    output logic [CHANNELS-1:0] timerWaveformOutputPin,
    output logic [CHANNELS-1:0] intelligentIoServiceReq,
    output logic [CHANNELS-1:0] underflowIrq
);
    logic [rdt_pkg::PRESCALE_WIDTH-1:0] prescaleQ;
    logic [2:0] prescaleTick;
    logic wrEn;
    logic rdEn;
    logic [31:0] rdataD;
    logic errD;
    logic [31:0] rdataQ;
    logic errQ;

    // Ticks when the low bits of the prescaler all reach one
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prescaleQ <= '0;
        end else begin
            prescaleQ <= prescaleQ + 5'h01;
        end
    end
    assign prescaleTick[0] = &prescaleQ[rdt_pkg::PRESCALE_EXP0-1:0];
    assign prescaleTick[1] = &prescaleQ[rdt_pkg::PRESCALE_EXP1-1:0];
    assign prescaleTick[2] = &prescaleQ[rdt_pkg::PRESCALE_EXP2-1:0];

    // Zero wait state slave: setup then one access cycle
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & ~penable & ~pwrite;
    assign pready = 1'b1;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
        input logic [3:0] strb);
        merge16 = old;
        if (strb[0]) begin
            merge16[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            merge16[15:8] = wd[15:8];
        end
    endfunction

    function automatic logic [1:0] regSel(input logic [7:0] addr);
        regSel = addr[3:2];
    endfunction

    logic [15:0] ctrlQ [CHANNELS];
    logic [15:0] reloadQ [CHANNELS];
    logic [15:0] cntView [CHANNELS];
    logic [CHANNELS-1:0] hitChan;
    logic [CHANNELS-1:0] flagView;
    logic [CHANNELS-1:0] runView;
    logic [CHANNELS-1:0] outView;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_chan
            rdt_chan_if cif();
            logic trigD;
            logic clrD;
            logic ufPulse;
            logic trig_q;
            assign hitChan[g] = (paddr[7:4] == 4'(g)) && (paddr[1:0] == 2'h0);
            assign trigD = wrEn && hitChan[g] && regSel(paddr) == 2'h0 && pstrb[0] &&
                pwdata[rdt_pkg::CTRL_TRIGGER_BIT];
            // Flag clears by writing zero to it
            assign clrD = wrEn && hitChan[g] && regSel(paddr) == 2'h0 && pstrb[1] &&
                !pwdata[rdt_pkg::CTRL_UNDERFLOW_BIT];
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    ctrlQ[g] <= rdt_pkg::CTRL_RESET;
                    reloadQ[g] <= rdt_pkg::RELOAD_RESET;
                end else if (wrEn && hitChan[g]) begin
                    if (regSel(paddr) == 2'h0) begin
                        ctrlQ[g] <= merge16(ctrlQ[g], pwdata, pstrb);
                    end else if (regSel(paddr) == 2'h1) begin
                        reloadQ[g] <= merge16(reloadQ[g], pwdata, pstrb);
                    end
                end
            end
            assign cif.ctrl = ctrlQ[g];
            assign cif.reload = reloadQ[g];
            // Start acts one cycle after the write so it sees the new enable and mode
            always_ff @(posedge core_clk or posedge sys_rst) begin
                if (sys_rst) begin
                    trig_q <= 1'b0;
                end else begin
                    trig_q <= trigD;
                end
            end
            assign cif.trigWrite = trig_q;
            assign cif.flagClear = clrD;
            rdt_channel u_chan (
                .core_clk(core_clk),
                .sys_rst(sys_rst),
                .prescaleTick(prescaleTick),
                .eventIn(timerEventInputPin[g]),
                .underflowPulse(ufPulse),
                .bus(cif.chan)
            );
            assign cntView[g] = cif.count;
            assign flagView[g] = cif.underflowFlag;
            assign runView[g] = cif.running;
            assign outView[g] = cif.outLevel;
            assign timerWaveformOutputPin[g] = cif.outLevel &
                ctrlQ[g][rdt_pkg::CTRL_OUT_ENABLE_BIT];
            assign underflowIrq[g] = cif.underflowFlag &
                ctrlQ[g][rdt_pkg::CTRL_IRQ_ENABLE_BIT];
            assign intelligentIoServiceReq[g] = ufPulse &
                ctrlQ[g][rdt_pkg::CTRL_IRQ_ENABLE_BIT];
        end
    endgenerate

    // Trigger bit always reads zero; status bits reflect channel state
    always_comb begin
        rdataD = 32'h0000_0000;
        errD = 1'b1;
        for (int i = 0; i < CHANNELS; i++) begin
            if (hitChan[i]) begin
                case (regSel(paddr))
                    2'h0: begin
                        rdataD[15:0] = ctrlQ[i];
                        rdataD[rdt_pkg::CTRL_TRIGGER_BIT] = 1'b0;
                        rdataD[rdt_pkg::CTRL_UNDERFLOW_BIT] = flagView[i];
                        rdataD[rdt_pkg::CTRL_RUNNING_BIT] = runView[i];
                        rdataD[rdt_pkg::CTRL_OUTLEVEL_BIT] = outView[i];
                        errD = 1'b0;
                    end
                    2'h1: begin
                        rdataD[15:0] = reloadQ[i];
                        errD = 1'b0;
                    end
                    2'h2: begin
                        rdataD[15:0] = cntView[i];
                        errD = 1'b0;
                    end
                    default: begin
                        errD = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdataQ <= 32'h0000_0000;
            errQ <= 1'b0;
        end else if (rdEn) begin
            rdataQ <= rdataD;
            errQ <= errD;
        end else if (psel && !penable) begin
            rdataQ <= 32'h0000_0000;
            errQ <= errD;
        end
    end
    assign prdata = rdataQ;
    assign pslverr = errQ & psel & penable;
endmodule
`default_nettype wire

// ### core/rdt_pkg.sv
package rdt_pkg;
    // Register byte addresses, two channels, each one aligned word
    localparam logic [7:0] CTRL0_OFFSET = 8'h00;
    localparam logic [7:0] RELOAD0_OFFSET = 8'h04;
    localparam logic [7:0] COUNT0_OFFSET = 8'h08;
    localparam logic [7:0] CTRL1_OFFSET = 8'h10;
    localparam logic [7:0] RELOAD1_OFFSET = 8'h14;
    localparam logic [7:0] COUNT1_OFFSET = 8'h18;
    localparam logic [7:0] CHAN_STRIDE = 8'h10;
    // Control and status register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_TRIGGER_BIT = 1;
    localparam int CTRL_RELOAD_MODE_BIT = 2;
    localparam int CTRL_EVENT_MODE_BIT = 3;
    localparam int CTRL_CLKSEL_LSB = 4;
    localparam int CTRL_START_LSB = 6;
    localparam int CTRL_EDGE_LSB = 8;
    localparam int CTRL_GATE_LEVEL_BIT = 10;
    localparam int CTRL_OUT_ENABLE_BIT = 11;
    localparam int CTRL_IRQ_ENABLE_BIT = 12;
    localparam int CTRL_UNDERFLOW_BIT = 13;
    localparam int CTRL_RUNNING_BIT = 14;
    localparam int CTRL_OUTLEVEL_BIT = 15;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // Prescaler divide exponents: machine clock over 2, 8 and 32
    localparam int PRESCALE_EXP0 = 1;
    localparam int PRESCALE_EXP1 = 3;
    localparam int PRESCALE_EXP2 = 5;
    localparam int PRESCALE_WIDTH = 5;
    typedef enum logic [1:0] {START_SOFT, START_EDGE, START_GATE, START_RSVD} rdt_start_type;
    typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} rdt_edge_type;
endpackage

// ### core/rdt_chan_if.sv
`timescale 1ns/10ps
`default_nettype none
interface rdt_chan_if;
    logic [15:0] ctrl;
    logic [15:0] reload;
    logic trigWrite;
    logic flagClear;
    logic [15:0] count;
    logic running;
    logic underflowFlag;
    logic outLevel;
    modport regs (output ctrl, output reload, output trigWrite, output flagClear,
        input count, input running, input underflowFlag, input outLevel);
    modport chan (input ctrl, input reload, input trigWrite, input flagClear,
        output count, output running, output underflowFlag, output outLevel);
endinterface
`default_nettype wire

// ### core/rdt_channel.sv
`timescale 1ns/10ps
`default_nettype none
module rdt_channel (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [2:0] prescaleTick,
    input wire logic eventIn,
    output logic underflowPulse,
    rdt_chan_if.chan bus
);
    logic [15:0] countQ;
    logic runningQ;
    logic flagQ;
    logic outQ;
    logic inPrevQ;
    logic rise;
    logic fall;
    logic edgeHit;
    logic startHit;
    logic tick;
    logic gateOk;
    logic armed;
    logic [1:0] clkSel;
    rdt_pkg::rdt_start_type startSel;
    rdt_pkg::rdt_edge_type edgeSel;

    assign armed = bus.ctrl[rdt_pkg::CTRL_ENABLE_BIT];
    assign clkSel = bus.ctrl[rdt_pkg::CTRL_CLKSEL_LSB +: 2];
    assign startSel = rdt_pkg::rdt_start_type'(bus.ctrl[rdt_pkg::CTRL_START_LSB +: 2]);
    assign edgeSel = rdt_pkg::rdt_edge_type'(bus.ctrl[rdt_pkg::CTRL_EDGE_LSB +: 2]);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            inPrevQ <= 1'b0;
        end else begin
            inPrevQ <= eventIn;
        end
    end
    assign rise = eventIn & ~inPrevQ;
    assign fall = ~eventIn & inPrevQ;

    always_comb begin
        case (edgeSel)
            rdt_pkg::EDGE_RISE: edgeHit = rise;
            rdt_pkg::EDGE_FALL: edgeHit = fall;
            rdt_pkg::EDGE_BOTH: edgeHit = rise | fall;
            default: edgeHit = 1'b0;
        endcase
    end

    // Software trigger stays a start source in every start mode
    always_comb begin
        startHit = bus.trigWrite;
        if (startSel == rdt_pkg::START_EDGE) begin
            startHit = bus.trigWrite | edgeHit;
        end
    end

    assign gateOk = (startSel != rdt_pkg::START_GATE) ||
        (eventIn == bus.ctrl[rdt_pkg::CTRL_GATE_LEVEL_BIT]);

    always_comb begin
        if (bus.ctrl[rdt_pkg::CTRL_EVENT_MODE_BIT]) begin
            tick = edgeHit;
        end else begin
            case (clkSel)
                2'h0: tick = prescaleTick[0];
                2'h1: tick = prescaleTick[1];
                2'h2: tick = prescaleTick[2];
                default: tick = 1'b0;
            endcase
            tick = tick & gateOk;
        end
    end

    assign underflowPulse = runningQ & tick & (countQ == 16'h0000);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            countQ <= rdt_pkg::COUNT_RESET;
            runningQ <= 1'b0;
        end else if (!armed) begin
            runningQ <= 1'b0;
        end else if (startHit) begin
            countQ <= bus.reload;
            runningQ <= 1'b1;
        end else if (underflowPulse) begin
            // Reload value N gives N+1 ticks between underflows
            if (bus.ctrl[rdt_pkg::CTRL_RELOAD_MODE_BIT]) begin
                countQ <= bus.reload;
            end else begin
                countQ <= 16'hffff;
                runningQ <= 1'b0;
            end
        end else if (runningQ && tick) begin
            countQ <= countQ - 16'h0001;
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flagQ <= 1'b0;
        end else if (underflowPulse) begin
            flagQ <= 1'b1;
        end else if (bus.flagClear) begin
            flagQ <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            outQ <= 1'b0;
        end else if (bus.ctrl[rdt_pkg::CTRL_RELOAD_MODE_BIT]) begin
            if (underflowPulse) begin
                outQ <= ~outQ;
            end
        end else begin
            outQ <= runningQ;
        end
    end

    assign bus.count = countQ;
    assign bus.running = runningQ;
    assign bus.underflowFlag = flagQ;
    assign bus.outLevel = outQ;

    a_oneshot_stops: assert property (@(posedge core_clk) disable iff (sys_rst)
        (underflowPulse && !bus.ctrl[rdt_pkg::CTRL_RELOAD_MODE_BIT] && !startHit && armed)
        |=> !runningQ && countQ == 16'hffff)
        else $error("one-shot did not stop at underflow");
    a_reload_reloads: assert property (@(posedge core_clk) disable iff (sys_rst)
        (underflowPulse && bus.ctrl[rdt_pkg::CTRL_RELOAD_MODE_BIT] && !startHit && armed)
        |=> runningQ && countQ == $past(bus.reload))
        else $error("reload mode did not reload");
    a_flag_sets: assert property (@(posedge core_clk) disable iff (sys_rst)
        underflowPulse |=> flagQ)
        else $error("underflow flag not set");
    a_start_loads: assert property (@(posedge core_clk) disable iff (sys_rst)
        (armed && startHit) |=> runningQ && countQ == $past(bus.reload))
        else $error("start did not load reload value");
    a_gate_pauses: assert property (@(posedge core_clk) disable iff (sys_rst)
        (armed && !startHit && !gateOk && !bus.ctrl[rdt_pkg::CTRL_EVENT_MODE_BIT])
        |=> $stable(countQ))
        else $error("counter moved with gate closed");
    a_toggle_out: assert property (@(posedge core_clk) disable iff (sys_rst)
        (underflowPulse && bus.ctrl[rdt_pkg::CTRL_RELOAD_MODE_BIT]) |=> outQ != $past(outQ))
        else $error("output did not toggle");
    a_event_step: assert property (@(posedge core_clk) disable iff (sys_rst)
        (armed && runningQ && !startHit && bus.ctrl[rdt_pkg::CTRL_EVENT_MODE_BIT]
        && !edgeHit) |=> $stable(countQ))
        else $error("event count moved without edge");
    a_count_steps: assert property (@(posedge core_clk) disable iff (sys_rst)
        (armed && runningQ && tick && !startHit && countQ != 16'h0000)
        |=> countQ == $past(countQ) - 16'h0001)
        else $error("counter did not step down by one");
endmodule
`default_nettype wire

// ### tb/rdt_event_src.sv
`timescale 1ns/10ps
`default_nettype none
module rdt_event_src (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic levelReq,
    input wire logic [3:0] toggleGap,
    output logic pinLevel
);
    logic [3:0] gapCnt_q;
    // Gap zero holds a level; otherwise the pin runs as an event clock
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinLevel <= 1'b0;
            gapCnt_q <= 4'h0;
        end else if (toggleGap == 4'h0) begin
            pinLevel <= levelReq;
            gapCnt_q <= 4'h0;
        end else if (gapCnt_q + 4'h1 >= toggleGap) begin
            pinLevel <= ~pinLevel;
            gapCnt_q <= 4'h0;
        end else begin
            gapCnt_q <= gapCnt_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ### tb/reload_down_timer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module reload_down_timer_tb;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] evPin;
    logic [1:0] outPin;
    logic [1:0] ioReq;
    logic [1:0] irq;
    logic [1:0] levelReq = 2'b00;
    logic [3:0] gap1 = 4'h0;
    int mismatches = 0;
    int cmp_count = 0;
    int n;
    logic [31:0] r;
    logic [31:0] r2;
    logic e;
    logic p;

    always #20 core_clk = ~core_clk;

    rdt_top #(.CHANNELS(2)) uut (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .timerEventInputPin(evPin),
        .timerWaveformOutputPin(outPin), .intelligentIoServiceReq(ioReq),
        .underflowIrq(irq));
    rdt_event_src src0 (.core_clk(core_clk), .sys_rst(sys_rst), .levelReq(levelReq[0]),
        .toggleGap(4'h0), .pinLevel(evPin[0]));
    rdt_event_src src1 (.core_clk(core_clk), .sys_rst(sys_rst), .levelReq(levelReq[1]),
        .toggleGap(gap1), .pinLevel(evPin[1]));

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Request held from setup until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        int k;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            chk("pready", 32'h1, 32'h0);
            end_of_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, {16'h0000, d}, x, y);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        logic y;
        apb(1'b0, a, 32'h0, x, y);
    endtask

    // Counts cycles up to the next service request pulse of a channel
    task automatic waitReq(input int ch, output int cnt);
        cnt = 0;
        do begin
            @(posedge core_clk);
            #1;
            cnt++;
        end while (ioReq[ch] !== 1'b1 && cnt < 3000);
        if (cnt >= 3000) begin
            chk("service request", 32'h1, 32'h0);
            end_of_test();
        end
    endtask

    task automatic testReset();
        rd(rdt_pkg::CTRL0_OFFSET, r);
        chk("ctrl0 reset", 32'h0, r);
        rd(rdt_pkg::RELOAD0_OFFSET, r);
        chk("reload0 reset", 32'h0, r);
        apb(1'b0, 8'h0c, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        $display("reset test done");
    endtask

    task automatic testReload();
        wr(rdt_pkg::RELOAD0_OFFSET, 16'h0003);
        wr(rdt_pkg::CTRL0_OFFSET, 16'h1807);
        waitReq(0, n);
        p = outPin[0];
        waitReq(0, n);
        chk("reload period", 32'd8, n);
        chk("toggle pin", {31'h0, ~p}, {31'h0, outPin[0]});
        chk("irq level", 32'h1, {31'h0, irq[0]});
        wr(rdt_pkg::CTRL0_OFFSET, 16'h1000);
        @(posedge core_clk);
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq[0]});
        $display("reload test done");
    endtask

    task automatic testOneShot();
        wr(rdt_pkg::RELOAD0_OFFSET, 16'h0001);
        wr(rdt_pkg::CTRL0_OFFSET, 16'h1813);
        repeat (2) @(posedge core_clk);
        #1;
        chk("pulse pin high", 32'h1, {31'h0, outPin[0]});
        waitReq(0, n);
        repeat (3) @(posedge core_clk);
        rd(rdt_pkg::COUNT0_OFFSET, r);
        chk("count after underflow", 32'h0000ffff, r);
        rd(rdt_pkg::CTRL0_OFFSET, r);
        chk("running after stop", 32'h0, {31'h0, r[14]});
        chk("pulse pin low", 32'h0, {31'h0, outPin[0]});
        wr(rdt_pkg::CTRL0_OFFSET, 16'h0000);
        $display("one-shot test done");
    endtask

    task automatic testEdgeStart();
        wr(rdt_pkg::RELOAD1_OFFSET, 16'd20);
        wr(rdt_pkg::CTRL1_OFFSET, 16'h1141);
        repeat (10) @(posedge core_clk);
        rd(rdt_pkg::COUNT1_OFFSET, r);
        chk("count held", 32'h0, r);
        levelReq[1] <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd(rdt_pkg::CTRL1_OFFSET, r);
        chk("edge start", 32'h1, {31'h0, r[14]});
        rd(rdt_pkg::COUNT1_OFFSET, r);
        p = r[15:0] <= 16'd20 && r[15:0] != 16'h0;
        chk("loaded count", 32'h1, {31'h0, p});
        waitReq(1, n);
        wr(rdt_pkg::CTRL1_OFFSET, 16'h1143);
        rd(rdt_pkg::CTRL1_OFFSET, r);
        chk("soft start in edge mode", 32'h1, {31'h0, r[14]});
        waitReq(1, n);
        levelReq[1] <= 1'b0;
        $display("edge start test done");
    endtask

    task automatic testGate();
        wr(rdt_pkg::RELOAD0_OFFSET, 16'h0100);
        wr(rdt_pkg::CTRL0_OFFSET, 16'h0487);
        rd(rdt_pkg::COUNT0_OFFSET, r);
        chk("gate loaded", 32'h0000_0100, r);
        rd(rdt_pkg::COUNT0_OFFSET, r2);
        chk("gate closed", 32'h0000_0100, r2);
        levelReq[0] <= 1'b1;
        repeat (6) @(posedge core_clk);
        rd(rdt_pkg::COUNT0_OFFSET, r);
        chk("gate open", 32'h1, {31'h0, r[15:0] < r2[15:0]});
        wr(rdt_pkg::CTRL0_OFFSET, 16'h0000);
        levelReq[0] <= 1'b0;
        $display("gate test done");
    endtask

    task automatic testEvent();
        wr(rdt_pkg::RELOAD1_OFFSET, 16'h0003);
        wr(rdt_pkg::CTRL1_OFFSET, 16'h133f);
        gap1 <= 4'h3;
        waitReq(1, n);
        waitReq(1, n);
        chk("event period", 32'd12, n);
        gap1 <= 4'h0;
        wr(rdt_pkg::CTRL1_OFFSET, 16'h0000);
        $display("event test done");
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        testReset();
        testReload();
        testOneShot();
        testEdgeStart();
        testGate();
        testEvent();
        end_of_test();
    end
endmodule
`default_nettype wire
